/* File: design/sss_ctrl.sv */
// Control logic of a synchronous flow-through burst memory: select decode, stall,
// sleep and data pin drive. Assumes pins are asynchronous to clock_i and pass
// two flip-flops; the array is held locally as a small memory.
`timescale 1ns/10ps
`default_nettype none
module sss_ctrl #(
   parameter int ADDR_W = sss_pkg::ADDR_W,
   parameter int DATA_W = sss_pkg::DATA_W
) (
   input wire logic clock_i, // System clock.
   input wire logic nrst_i, // Asynchronous reset, active low.
   input wire logic ce_i, // Block clock enable; freezes all state when low.
   input wire logic chip_select_first_low_i, // First select, active low.
   input wire logic chip_select_second_high_i, // Second select, active high.
   input wire logic chip_select_third_low_i, // Third select, active low.
   input wire logic clock_gate_n_i, // Clock gate, active low.
   input wire logic sleep_pin_i, // Sleep request, active high.
   input wire logic burst_order_i, // Burst order strap.
   input wire logic write_n_i, // Write command, active low.
   input wire logic advance_i, // High continues a burst, low loads a new address.
   input wire logic [ADDR_W-1:0] addr_i, // Address pins.
   input wire logic [DATA_W-1:0] dq_i, // Data pins, as read back.
   output logic [DATA_W-1:0] dq_o, // Data pins, driven value.
   output logic dq_oe_n_o, // Data pin enable, low while driving.
   output logic selected_o, // Device selected on the last taken edge.
   output logic sleeping_o // Sleep mode active.
);
   localparam int DEPTH = 1 << ADDR_W;

   // ==========================================================
   // Pin synchronisers
   localparam int NSYNC = 8;
   // Bit positions of the control pins inside the synchroniser word.
   localparam int POS_CS1_N = 7;
   localparam int POS_CS2 = 6;
   localparam int POS_CS3_N = 5;
   localparam int POS_GATE_N = 4;
   localparam int POS_SLEEP = 3;
   localparam int POS_ORDER = 2;
   localparam int POS_WR_N = 1;
   localparam int POS_ADV = 0;
   // The stages wake deselected, stalled and awake, so no false command or sleep
   // entry can come out of reset before the real pins have been seen twice.
   localparam logic [NSYNC-1:0] PINS_RESET = {1'b1, 1'b0, 1'b0, 1'b1, 1'b0,
                                             sss_pkg::ORDER_LINEAR, 1'b1, 1'b0};
   logic [NSYNC-1:0] pins_raw;
   logic [NSYNC-1:0] pins_meta;
   logic [NSYNC-1:0] pins;
   logic [ADDR_W-1:0] addr_meta;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] dq_meta;
   logic [DATA_W-1:0] dq_s;

   assign pins_raw = {chip_select_first_low_i, chip_select_second_high_i,
                      chip_select_third_low_i, clock_gate_n_i, sleep_pin_i,
                      burst_order_i, write_n_i, advance_i};

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pins_meta <= PINS_RESET;
         pins <= PINS_RESET;
      end else if (ce_i) begin
         pins_meta <= pins_raw;
         pins <= pins_meta;
      end
   end

   // Address and data pass the same two stages, so they line up with the controls.
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         addr_meta <= '0;
         addr_s <= '0;
         dq_meta <= '0;
         dq_s <= '0;
      end else if (ce_i) begin
         addr_meta <= addr_i;
         addr_s <= addr_meta;
         dq_meta <= dq_i;
         dq_s <= dq_meta;
      end
   end

   // ==========================================================
   // Decode
   wire cs1_n = pins[POS_CS1_N];
   wire cs2 = pins[POS_CS2];
   wire cs3_n = pins[POS_CS3_N];
   wire gate_n = pins[POS_GATE_N];
   wire sleep_req = pins[POS_SLEEP];
   wire order = pins[POS_ORDER];
   wire wr_n = pins[POS_WR_N];
   wire adv = pins[POS_ADV];

   wire sel = !cs1_n && cs2 && !cs3_n;
   // A high clock gate makes the edge a stall: no command or burst step is taken, nothing writes; sleep entry still happens.
   wire edge_taken = ce_i && !gate_n;

   sss_pkg::sss_state_t state;
   sss_pkg::sss_state_t next_state;
   logic drive_en;
   logic next_drive_en;
   logic [DATA_W-1:0] rdata;
   logic [ADDR_W-1:0] beat_addr;

   // Only a deselected device may go to sleep; a request while selected is held off.
   wire enter_sleep = sleep_req && !sel;
   wire cmd_ok = (state != sss_pkg::SSS_SLEEP) && !sleep_req;
   // A continuation only counts while the selects still decode as selected.
   wire is_burst = adv && sel && (state == sss_pkg::SSS_READ || state == sss_pkg::SSS_WRITE);
   wire start = cmd_ok && sel && !adv;
   wire do_read = edge_taken && cmd_ok && ((start && wr_n) ||
                  (is_burst && state == sss_pkg::SSS_READ));
   wire do_write = edge_taken && cmd_ok && ((start && !wr_n) ||
                   (is_burst && state == sss_pkg::SSS_WRITE));

   // ==========================================================
   // Burst addressing
   // The generator wraps within four beats; a longer run revisits the same words.
   wire load_burst = edge_taken && start;
   wire step_burst = edge_taken && is_burst && cmd_ok;

   sss_burst_addr #(
      .ADDR_W(ADDR_W),
      .BURST_W(sss_pkg::BURST_W)
   ) u_burst (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .load_i(load_burst),
      .step_i(step_burst),
      .order_i(order),
      .addr_i(addr_s),
      .addr_o(beat_addr)
   );
   wire [ADDR_W-1:0] acc_addr = (start) ? addr_s : beat_addr;

   // ==========================================================
   // State sequence
   // Sleep is left on the first synchronised low of the sleep pin, whatever the gate says.
   always_comb begin
      next_state = state;
      next_drive_en = drive_en;
      case (state)
         sss_pkg::SSS_IDLE, sss_pkg::SSS_READ, sss_pkg::SSS_WRITE: begin
            if (enter_sleep) begin
               next_state = sss_pkg::SSS_SLEEP;
               next_drive_en = 1'b0;
            end else if (do_read) begin
               next_state = sss_pkg::SSS_READ;
               next_drive_en = 1'b1;
            end else if (do_write) begin
               next_state = sss_pkg::SSS_WRITE;
               next_drive_en = 1'b0;
            end else if (edge_taken) begin
               next_state = sss_pkg::SSS_IDLE;
               next_drive_en = 1'b0;
            end
         end
         sss_pkg::SSS_SLEEP: begin
            next_drive_en = 1'b0;
            if (!sleep_req) begin
               next_state = sss_pkg::SSS_IDLE;
            end
         end
         default: begin
            next_state = sss_pkg::SSS_IDLE;
            next_drive_en = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // Array
   // The array has no reset: a word read before it was ever written is unknown.
   logic [DATA_W-1:0] mem [DEPTH];

   always_ff @(posedge clock_i) begin
      if (do_write) begin
         mem[acc_addr] <= dq_s;
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= sss_pkg::SSS_IDLE;
         drive_en <= 1'b0;
      end else if (ce_i) begin
         state <= next_state;
         drive_en <= next_drive_en;
      end
   end

   // A stalled edge leaves the last decode standing, as the pins were never taken.
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         selected_o <= 1'b0;
      end else if (edge_taken) begin
         selected_o <= sel;
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata <= '0;
      end else if (do_read) begin
         rdata <= mem[acc_addr];
      end
   end

   // ==========================================================
   // Outputs
   // Read data stands in its register until the next read replaces it.
   assign dq_o = rdata;
   assign dq_oe_n_o = !drive_en;
   assign sleeping_o = (state == sss_pkg::SSS_SLEEP);
endmodule
`default_nettype wire

/* File: design/sss_pkg.sv */
// Package for the synchronous flow-through burst memory control block.
// Assumes a single 100 MHz clock domain; no other file defines these names.
package sss_pkg;
   // ==========================================================
   // Widths and encodings
   localparam int ADDR_W = 10;
   localparam int DATA_W = 36;
   localparam int BURST_W = 2;
   localparam logic ORDER_LINEAR = 1'h0;
   localparam logic ORDER_INTERLEAVED = 1'h1;
   localparam logic [1:0] BURST_START = 2'h0;
   localparam logic [1:0] BURST_STEP = 2'h1;

   // ==========================================================
   // Operating states, Gray coded along idle, read, write.
   typedef enum logic [1:0] {
      SSS_IDLE  = 2'h0,
      SSS_READ  = 2'h1,
      SSS_WRITE = 2'h3,
      SSS_SLEEP = 2'h2
   } sss_state_t;
endpackage

/* File: design/sss_burst_addr.sv */
// Burst address generator: linear or interleaved order of the low address bits.
// Assumes load and step are qualified by the caller's clock enable.
`timescale 1ns/10ps
`default_nettype none
module sss_burst_addr #(
   parameter int ADDR_W = sss_pkg::ADDR_W,
   parameter int BURST_W = sss_pkg::BURST_W
) (
   input wire logic clock_i, // System clock.
   input wire logic nrst_i, // Asynchronous reset, active low.
   input wire logic load_i, // Capture a new start address.
   input wire logic step_i, // Advance one beat of the burst.
   input wire logic order_i, // Burst order strap, already synchronised.
   input wire logic [ADDR_W-1:0] addr_i, // Start address.
   output logic [ADDR_W-1:0] addr_o // Current beat address.
);
   logic [ADDR_W-1:0] base;
   logic [BURST_W-1:0] count;
   logic [BURST_W-1:0] next_count;
   logic [BURST_W-1:0] low_bits;

   // ==========================================================
   // Beat selection
   // The start beat is taken by the load itself, so count always names the beat that
   // the next continuation will reach; a load therefore leaves it one step on.
   assign next_count = load_i ? BURST_W'(sss_pkg::BURST_START + sss_pkg::BURST_STEP) :
                       BURST_W'(count + sss_pkg::BURST_STEP);
   assign low_bits = (order_i == sss_pkg::ORDER_INTERLEAVED) ?
                     (base[BURST_W-1:0] ^ count) :
                     BURST_W'(base[BURST_W-1:0] + count);
   assign addr_o = {base[ADDR_W-1:BURST_W], low_bits};

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         base <= '0;
         count <= '0;
      end else if (load_i || step_i) begin
         count <= next_count;
         if (load_i) begin
            base <= addr_i;
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb/sss_ctrl_assertions.sv */
// Checker of the memory control block: select, stall and sleep at its ports.
// Assumes it is bound to the control block and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module sss_ctrl_checker #(
   parameter int DATA_W = sss_pkg::DATA_W
) (
   input wire logic clock_i, // Clock.
   input wire logic nrst_i, // Reset.
   input wire logic ce_i, // Enable.
   input wire logic chip_select_first_low_i, // Select 1.
   input wire logic chip_select_second_high_i, // Select 2.
   input wire logic chip_select_third_low_i, // Select 3.
   input wire logic clock_gate_n_i, // Gate.
   input wire logic sleep_pin_i, // Sleep.
   input wire logic [DATA_W-1:0] dq_o, // Data.
   input wire logic dq_oe_n_o, // Drive.
   input wire logic selected_o, // Selected.
   input wire logic sleeping_o // Asleep.
);
   // ====
   // Pins are held three cycles so that both synchroniser stages have filled.
   default clocking @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   wire pick = !chip_select_first_low_i && chip_select_second_high_i && !chip_select_third_low_i;
   wire go = ce_i && !clock_gate_n_i && !sleep_pin_i;
   sequence held_sel; (go && pick) [*3]; endsequence
   sequence held_desel; (go && !pick) [*3]; endsequence
   sequence held_stall; (ce_i && clock_gate_n_i && !sleep_pin_i) [*3]; endsequence
   sel_decode_a: assert property (held_sel |-> ##[0:2] selected_o)
      else $error("select decode missed");
   desel_decode_a: assert property (held_desel |-> ##[0:2] !selected_o)
      else $error("deselect decode missed");
   desel_quiet_a: assert property (!selected_o |-> dq_oe_n_o)
      else $error("data driven while deselected");
   stall_hold_a: assert property (held_stall |=> $stable(dq_o) && $stable(selected_o))
      else $error("state moved in a stall");
   sleep_quiet_a: assert property (sleeping_o |-> dq_oe_n_o)
      else $error("data driven while asleep");
   wake_off_a: assert property ($fell(sleeping_o) |-> dq_oe_n_o)
      else $error("data driven on wake");
endmodule
bind sss_ctrl sss_ctrl_checker #(.DATA_W(DATA_W)) chk_u (.*);
`default_nettype wire

/* File: tb/sss_ctl_model.sv */
// Controller model: drives the synchronous pins of the memory control block.
// Assumes the bench calls its cycle task once per clock.
`timescale 1ns/10ps
`default_nettype none
module sss_ctl_model (
   input wire logic clock_i, // Clock.
   output logic [2:0] cs_o, // Selects 1, 2, 3.
   output logic gate_n_o, // Gate.
   output logic sleep_o, // Sleep.
   output logic write_n_o, // Write, low.
   output logic adv_o, // Burst continue.
   output logic [sss_pkg::ADDR_W-1:0] addr_o, // Address.
   output logic [sss_pkg::DATA_W-1:0] dq_o // Write data.
);
   initial begin
      {cs_o, gate_n_o, sleep_o, write_n_o, adv_o} = 7'h42;
      addr_o = '0;
      dq_o = '0;
   end
   // ====
   // Outside a write the data lines flip, so stale data never looks valid.
   task automatic cyc(input logic [2:0] c, input logic g, input logic s, input logic w,
      input logic a, input logic [9:0] ad, input logic [35:0] d);
      @(posedge clock_i);
      {cs_o, gate_n_o, sleep_o, write_n_o, adv_o} <= {c, g, s, w, a};
      addr_o <= ad;
      dq_o <= w ? ~dq_o : d;
   endtask
endmodule
`default_nettype wire

/* File: tb/sync_sram_select_stall_sleep_tb.sv */
// Bench of the memory control block: selects, stalls, sleep and burst order.
// Assumes the controller model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module sync_sram_select_stall_sleep_tb;
   logic clock_i = 1'b0;
   logic nrst_i = 1'b0;
   logic order = 1'b0;
   logic ce = 1'b1;
   logic [2:0] cs;
   logic gate_n, slp, wr_n, adv, oe_n, zz, sel;
   logic [9:0] addr;
   logic [35:0] m_dq, r_dq, dq_w;
   logic [35:0] e [8];
   int errors = 0;
   int tests_run = 0;
   always #5 clock_i = ~clock_i;
   assign dq_w = oe_n ? m_dq : r_dq;
   sss_ctl_model ctl_u (.clock_i(clock_i), .cs_o(cs), .gate_n_o(gate_n), .sleep_o(slp),
      .write_n_o(wr_n), .adv_o(adv), .addr_o(addr), .dq_o(m_dq));
   sss_ctrl dut_u (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce),
      .chip_select_first_low_i(cs[2]), .chip_select_second_high_i(cs[1]),
      .chip_select_third_low_i(cs[0]), .clock_gate_n_i(gate_n), .sleep_pin_i(slp),
      .burst_order_i(order), .write_n_i(wr_n), .advance_i(adv), .addr_i(addr), .dq_i(dq_w),
      .dq_o(r_dq), .dq_oe_n_o(oe_n), .selected_o(sel), .sleeping_o(zz));
   // ====
   task automatic results();
      $display("compares %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wt(input bit on_zz, input logic v);
      for (int n = 0; n < 8 && (on_zz ? zz : oe_n) !== v; n++) begin
         @(posedge clock_i);
         #1;
      end
      chk(36'(on_zz ? zz : oe_n), 36'(v));
      if ((on_zz ? zz : oe_n) !== v) results();
   endtask
   task automatic idl();
      ctl_u.cyc(3'b100, 1'b0, 1'b0, 1'b1, 1'b0, 10'h0, 36'h0);
   endtask
   task automatic wr(input logic [2:0] c, input logic g, input logic [9:0] a,
      input logic [35:0] d);
      ctl_u.cyc(c, g, 1'b0, 1'b0, 1'b0, a, d);
      idl();
   endtask
   task automatic rd(input logic [9:0] a, input logic [35:0] x);
      ctl_u.cyc(3'b010, 1'b0, 1'b0, 1'b1, 1'b0, a, 36'h0);
      idl();
      wt(1'b0, 1'b0);
      chk(r_dq, x);
   endtask
   // ====
   initial begin
      repeat (4) @(posedge clock_i);
      nrst_i <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         e[i] = 36'h100 + 36'(i);
         wr(3'b010, 1'b0, 10'(i), e[i]);
      end
      for (int i = 0; i < 8; i++) begin
         wr(3'(i), 1'b0, 10'(i), 36'h200);
         if (i == 2) e[i] = 36'h200;
      end
      wr(3'b010, 1'b1, 10'h3, 36'h300);
      for (int i = 0; i < 8; i++) rd(10'(i), e[i]);
      // A read followed at once by three stalls: its data must stand, no write lands.
      ctl_u.cyc(3'b010, 1'b0, 1'b0, 1'b1, 1'b0, 10'h3, 36'h0);
      repeat (3) ctl_u.cyc(3'b010, 1'b1, 1'b0, 1'b0, 1'b0, 10'h5, 36'h600);
      idl();
      #1;
      chk(36'(oe_n), 36'h0);
      chk(r_dq, e[3]);
      chk(36'(sel), 36'h1);
      // With the block enable low even the pin stages freeze, so this write is lost.
      @(posedge clock_i);
      ce <= 1'b0;
      ctl_u.cyc(3'b010, 1'b0, 1'b0, 1'b0, 1'b0, 10'h6, 36'h700);
      idl();
      repeat (2) @(posedge clock_i);
      ce <= 1'b1;
      repeat (2) idl();
      rd(10'h5, e[5]);
      rd(10'h6, e[6]);
      ctl_u.cyc(3'b100, 1'b0, 1'b1, 1'b1, 1'b0, 10'h0, 36'h0);
      wt(1'b1, 1'b1);
      chk(36'(sel), 36'h0);
      ctl_u.cyc(3'b010, 1'b0, 1'b1, 1'b0, 1'b0, 10'h4, 36'h400);
      idl();
      wt(1'b1, 1'b0);
      chk(36'(oe_n), 36'h1);
      rd(10'h4, e[4]);
      for (int o = 0; o < 2; o++) begin
         @(posedge clock_i);
         order <= 1'(o);
         repeat (3) idl();
         for (int k = 0; k < 4; k++) ctl_u.cyc(3'b010, 1'b0, 1'b0, 1'b0, 1'(k != 0), 10'h1,
            36'h500 + 36'(k));
         idl();
         for (int j = 0; j < 4; j++) begin
            rd(10'(j), 36'h500 + 36'(o ? (j ^ 1) : ((j + 3) % 4)));
         end
      end
      results();
   end
endmodule
`default_nettype wire
